/* File: rtl/abr_pkg.sv */
// Constants, opcodes, states and carriers for the abort and residue block.
// Assumes one 100 MHz core clock and plain status ports, no register bus.
package abr_pkg;
  // Status and control bit positions
  localparam int IS_ABORT    = 7;
  localparam int IS_CONN     = 3;
  localparam int S0_CHOSEN   = 4;
  localparam int S1_IN_FULL  = 7;
  localparam int S1_HOLD     = 6;
  localparam int S1_OUT_FULL = 5;
  localparam int DF_CLEAR    = 6;
  // Sizes and counts
  localparam logic [31:0] INST_BYTES = 32'h8;
  localparam logic [5:0]  DF_MASK    = 6'h3f;
  localparam logic [3:0]  SF_DEPTH   = 4'h8;
  localparam logic [3:0]  SF_ONE     = 4'h1;
  localparam logic [5:0]  HELD_ONE   = 6'h1;
  localparam logic [23:0] DBC_ONE    = 24'h1;
  localparam logic [5:0]  DF_ONE     = 6'h1;

  typedef enum logic [2:0] {
    OP_MOVE       = 3'h0,
    OP_SELECT     = 3'h1,
    OP_RESELECT   = 3'h2,
    OP_WAIT_RESEL = 3'h3,
    OP_WAIT_SEL   = 3'h4,
    OP_STOP       = 3'h5
  } abr_op_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_FETCH = 3'h2,
    ST_EXEC  = 3'h4
  } abr_st_t;

  typedef struct packed {
    abr_op_t     op;
    logic [31:0] alt;
    logic [23:0] count;
  } abr_instr_t;

  typedef struct packed {
    logic selected;
    logic reselected;
    logic won;
    logic disconnect;
  } abr_evt_t;

  typedef struct packed {
    abr_st_t         st;
    logic [31:0]     dsp;
    abr_op_t         op;
    logic [31:0]     alt;
    logic [23:0]     dbc;
    logic [5:0]      dma_fifo_count_reg;
    logic [5:0]      held;
    logic            abort_req;
    logic            abort_irq;
    logic            conn;
    logic            chosen;
    logic            in_full;
    logic [7:0]      in_data;
    logic            out_full;
    logic            hold_full;
    logic [3:0]      sf_cnt;
    logic [2:0]      sf_wp;
    logic [2:0]      sf_rp;
    logic [7:0][7:0] sf_mem;
    logic [7:0]      port_data;
  } abr_state_t;
endpackage : abr_pkg

/* File: rtl/abr_core.sv */
// Script engine status: abort, connection, alternate jumps, residue counts.
// Assumes all inputs synchronous to i_clk; software strobes last one cycle.
`timescale 1ns/10ps
module abr_core (
  // Clock and reset
  input  wire logic                i_clk,
  input  wire logic                i_rst_n,
  // Software strobes
  input  wire logic                i_int_status_wr,
  input  wire logic [7:0]          i_int_status_data,
  input  wire logic                i_dsp_wr,
  input  wire logic [31:0]         i_dsp_data,
  input  wire logic                i_dma_status_rd,
  input  wire logic                i_scsi_status_0_rd,
  input  wire logic                i_input_latch_rd,
  input  wire logic                i_fifo_port_rd,
  input  wire logic                i_dma_fifo_wr,
  input  wire logic [7:0]          i_dma_fifo_data,
  // Instruction fetch
  input  wire logic                i_fetch_valid,
  input  wire abr_pkg::abr_instr_t i_fetch,
  // Bus events
  input  wire abr_pkg::abr_evt_t   i_evt,
  // Data path events
  input  wire logic                i_dir_rx,
  input  wire logic                i_burst_active,
  input  wire logic                i_async_rx_valid,
  input  wire logic [7:0]          i_async_rx_data,
  input  wire logic                i_in_latch_to_dma,
  input  wire logic                i_sync_rx_valid,
  input  wire logic [7:0]          i_sync_rx_data,
  input  wire logic                i_sfifo_to_dma,
  input  wire logic                i_rx_to_dma,
  input  wire logic                i_mem_byte,
  input  wire logic                i_dma_to_scsi,
  input  wire logic                i_out_latch_load,
  input  wire logic                i_out_latch_sent,
  input  wire logic                i_hold_load,
  input  wire logic                i_hold_sent,
  // Fetch request
  output logic                     o_fetch_req,
  output logic [31:0]              o_dsp,
  // Status
  output logic [7:0]               o_int_status,
  output logic [7:0]               o_scsi_status_0,
  output logic [7:0]               o_scsi_status_1,
  output logic [7:0]               o_scsi_status_2,
  output logic [23:0]              o_byte_counter,
  output logic [7:0]               o_dma_fifo_count,
  output logic [7:0]               o_input_latch,
  output logic [7:0]               o_fifo_port_data,
  output logic                     o_abort_irq
);
  abr_pkg::abr_state_t q;
  abr_pkg::abr_state_t d;
  logic abort_fire;
  logic chosen_ev;
  logic sf_push;
  logic sf_pop;
  logic clr;

  always_comb begin
    d = q;
    clr = i_dma_fifo_wr && i_dma_fifo_data[abr_pkg::DF_CLEAR];
    // Abort acts only after burst and received data have drained
    abort_fire = q.abort_req && !q.abort_irq && !i_burst_active
                 && (q.held == 6'h0);
    chosen_ev = 1'b0;
    if (i_int_status_wr) begin
      d.abort_req = i_int_status_data[abr_pkg::IS_ABORT];
    end
    if (i_dsp_wr) begin
      d.dsp = i_dsp_data;
      d.st = abr_pkg::ST_FETCH;
    end
    case (q.st)
      abr_pkg::ST_FETCH: begin
        if (i_fetch_valid) begin
          d.op = i_fetch.op;
          d.alt = i_fetch.alt;
          d.dsp = q.dsp + abr_pkg::INST_BYTES;
          d.st = abr_pkg::ST_EXEC;
          if (i_fetch.op == abr_pkg::OP_MOVE) begin
            d.dbc = i_fetch.count;
            d.dma_fifo_count_reg = i_fetch.count[5:0];
          end
        end
      end
      abr_pkg::ST_EXEC: begin
        case (q.op)
          abr_pkg::OP_SELECT, abr_pkg::OP_RESELECT: begin
            if (i_evt.selected || i_evt.reselected) begin
              d.dsp = q.alt;
              d.st = abr_pkg::ST_FETCH;
              chosen_ev = 1'b1;
            end else if (i_evt.won) begin
              d.conn = 1'b1;
              d.st = abr_pkg::ST_FETCH;
            end
          end
          abr_pkg::OP_WAIT_RESEL: begin
            if (i_evt.reselected) begin
              d.st = abr_pkg::ST_FETCH;
              chosen_ev = 1'b1;
            end else if (i_evt.selected) begin
              d.dsp = q.alt;
              d.st = abr_pkg::ST_FETCH;
              chosen_ev = 1'b1;
            end
          end
          abr_pkg::OP_WAIT_SEL: begin
            if (i_evt.selected) begin
              d.st = abr_pkg::ST_FETCH;
              chosen_ev = 1'b1;
            end else if (i_evt.reselected) begin
              d.dsp = q.alt;
              d.st = abr_pkg::ST_FETCH;
              chosen_ev = 1'b1;
            end
          end
          abr_pkg::OP_MOVE: begin
            if (q.dbc == 24'h0) begin
              d.st = abr_pkg::ST_FETCH;
            end
          end
          default: begin
            d.st = abr_pkg::ST_IDLE;
          end
        endcase
      end
      default: begin
      end
    endcase
    // Unexpected disconnect leaves pointer past the executing instruction
    if (i_evt.disconnect) begin
      d.conn = 1'b0;
      if (q.st == abr_pkg::ST_EXEC) begin
        d.st = abr_pkg::ST_IDLE;
      end
    end
    if (chosen_ev) begin
      d.conn = 1'b1;
    end
    // Abort halts fetch and holds the pointer, other state untouched
    if (abort_fire) begin
      d.st = abr_pkg::ST_IDLE;
      d.dsp = q.dsp;
    end
    d.abort_irq = abort_fire || (q.abort_irq && !i_dma_status_rd);
    d.chosen = chosen_ev || (q.chosen && !i_scsi_status_0_rd);
    // Byte counter counts down only with memory byte transfers, in either direction; a MOVE fetch loads it
    if (i_mem_byte && (q.dbc != 24'h0)) begin
      d.dbc = q.dbc - abr_pkg::DBC_ONE;
    end
    if (i_dma_to_scsi) begin
      d.dma_fifo_count_reg = q.dma_fifo_count_reg - abr_pkg::DF_ONE;
    end
    if (i_rx_to_dma && !(i_mem_byte && i_dir_rx)) begin
      d.held = q.held + abr_pkg::HELD_ONE;
    end else if (!i_rx_to_dma && i_mem_byte && i_dir_rx
                 && (q.held != 6'h0)) begin
      d.held = q.held - abr_pkg::HELD_ONE;
    end
    // Input latch
    if (i_async_rx_valid) begin
      d.in_full = 1'b1;
      d.in_data = i_async_rx_data;
    end else if (i_input_latch_rd || i_in_latch_to_dma) begin
      d.in_full = 1'b0;
    end
    d.out_full = i_out_latch_load || (q.out_full && !i_out_latch_sent);
    d.hold_full = i_hold_load || (q.hold_full && !i_hold_sent);
    // Receive FIFO
    sf_push = i_sync_rx_valid && (q.sf_cnt != abr_pkg::SF_DEPTH);
    sf_pop = (i_fifo_port_rd || i_sfifo_to_dma) && (q.sf_cnt != 4'h0);
    if (sf_push) begin
      d.sf_mem[q.sf_wp] = i_sync_rx_data;
      d.sf_wp = q.sf_wp + 3'h1;
    end
    if (sf_pop) begin
      d.sf_rp = q.sf_rp + 3'h1;
      if (i_fifo_port_rd) begin
        d.port_data = q.sf_mem[q.sf_rp];
      end
    end
    if (sf_push && !sf_pop) begin
      d.sf_cnt = q.sf_cnt + abr_pkg::SF_ONE;
    end else if (sf_pop && !sf_push) begin
      d.sf_cnt = q.sf_cnt - abr_pkg::SF_ONE;
    end
    // Clearing both FIFOs resyncs the running count to the counter
    if (clr) begin
      d.sf_cnt = 4'h0;
      d.sf_wp = 3'h0;
      d.sf_rp = 3'h0;
      d.held = 6'h0;
      d.dma_fifo_count_reg = d.dbc[5:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      q <= '0;
      q.st <= abr_pkg::ST_IDLE;
      q.op <= abr_pkg::OP_STOP;
    end else begin
      q <= d;
    end
  end

  assign o_fetch_req = q.st[1];
  assign o_dsp = q.dsp;
  assign o_int_status = {q.abort_req, 3'h0, q.conn, 3'h0};
  assign o_scsi_status_0 = {3'h0, q.chosen, 4'h0};
  assign o_scsi_status_1 = {q.in_full, q.hold_full, q.out_full, 5'h0};
  assign o_scsi_status_2 = {q.sf_cnt, 4'h0};
  assign o_byte_counter = q.dbc;
  assign o_dma_fifo_count = {2'h0, q.dma_fifo_count_reg};
  assign o_input_latch = q.in_data;
  assign o_fifo_port_data = q.port_data;
  assign o_abort_irq = q.abort_irq;

  logic in_wait_sel;
  assign in_wait_sel = (q.st == abr_pkg::ST_EXEC)
                       && (q.op == abr_pkg::OP_WAIT_SEL);
  sequence s_sel_wait;
    in_wait_sel && i_evt.selected && !i_evt.disconnect
    && !abort_fire && !i_dsp_wr;
  endsequence
  sequence s_next_fetch;
    (q.st == abr_pkg::ST_FETCH) && (q.dsp == $past(q.dsp));
  endsequence

  property p_conn;
    @(posedge i_clk) disable iff (!i_rst_n)
      chosen_ev && !i_evt.disconnect |=> o_int_status[abr_pkg::IS_CONN];
  endproperty
  a_conn: assert property (p_conn) else $error("connected not set");

  property p_abort_irq;
    @(posedge i_clk) disable iff (!i_rst_n)
      abort_fire |=> o_abort_irq && (q.st == abr_pkg::ST_IDLE);
  endproperty
  a_abort_irq: assert property (p_abort_irq) else $error("no abort irq");

  property p_chosen;
    @(posedge i_clk) disable iff (!i_rst_n)
      chosen_ev |=> o_scsi_status_0[abr_pkg::S0_CHOSEN];
  endproperty
  a_chosen: assert property (p_chosen) else $error("chosen not set");

  property p_dsp_step;
    @(posedge i_clk) disable iff (!i_rst_n)
      o_fetch_req && i_fetch_valid && !i_dsp_wr && !abort_fire
      |=> o_dsp == $past(o_dsp) + abr_pkg::INST_BYTES;
  endproperty
  a_dsp_step: assert property (p_dsp_step) else $error("dsp not +8");

  property p_wait_next;
    @(posedge i_clk) disable iff (!i_rst_n)
      s_sel_wait |=> s_next_fetch;
  endproperty
  a_wait_next: assert property (p_wait_next) else $error("no advance");

  property p_sel_alt;
    @(posedge i_clk) disable iff (!i_rst_n)
      (q.st == abr_pkg::ST_EXEC) && ((q.op == abr_pkg::OP_SELECT)
      || (q.op == abr_pkg::OP_RESELECT))
      && (i_evt.selected || i_evt.reselected) && !abort_fire && !i_dsp_wr
      |=> o_dsp == $past(q.alt);
  endproperty
  a_sel_alt: assert property (p_sel_alt) else $error("no alt jump");

  property p_wsel_alt;
    @(posedge i_clk) disable iff (!i_rst_n)
      in_wait_sel && i_evt.reselected && !i_evt.selected
      && !abort_fire && !i_dsp_wr |=> o_dsp == $past(q.alt);
  endproperty
  a_wsel_alt: assert property (p_wsel_alt) else $error("no alt jump");

  property p_dbc_hold;
    @(posedge i_clk) disable iff (!i_rst_n)
      !i_mem_byte && !(o_fetch_req && i_fetch_valid)
      |=> $stable(o_byte_counter);
  endproperty
  a_dbc_hold: assert property (p_dbc_hold) else $error("dbc moved");

  property p_clear;
    @(posedge i_clk) disable iff (!i_rst_n)
      clr |=> (o_scsi_status_2 == 8'h0)
              && (((o_dma_fifo_count[5:0] - o_byte_counter[5:0])
                  & abr_pkg::DF_MASK) == 6'h0);
  endproperty
  a_clear: assert property (p_clear) else $error("fifo not cleared");

  property p_irq_clr;
    @(posedge i_clk) disable iff (!i_rst_n)
      i_dma_status_rd && !abort_fire |=> !o_abort_irq;
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("irq not cleared");

  property p_req_hold;
    @(posedge i_clk) disable iff (!i_rst_n)
      o_int_status[abr_pkg::IS_ABORT] && !i_int_status_wr
      |=> o_int_status[abr_pkg::IS_ABORT];
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("abort req lost");
endmodule : abr_core

/* File: tb/abr_peer.sv */
// Peer bus controller: selection events and sync receive bytes.
// Assumes the bench calls its tasks just after a core clock edge.
`timescale 1ns/10ps
module abr_peer (
  // Clock
  input  wire logic         i_clk,
  // Bus side
  output abr_pkg::abr_evt_t o_evt,
  output logic              o_sv,
  output logic [7:0]        o_sd
);
  initial {o_evt, o_sv, o_sd} = 13'h0;
  // One event pulse, either role
  task automatic choose(input abr_pkg::abr_evt_t e);
    o_evt = e;
    @(posedge i_clk);
    #1 o_evt = '0;
  endtask : choose
  // One sync byte, then a gap; data inverted once released
  task automatic send(input logic [7:0] b);
    {o_sv, o_sd} = {1'b1, b};
    @(posedge i_clk);
    #1 {o_sv, o_sd} = {1'b0, ~b};
    @(posedge i_clk);
    #1;
  endtask : send
endmodule : abr_peer

/* File: tb/testbench.sv */
// Bench: strobe-level runs of the abort and residue block.
// Assumes the peer model for bus events and sync receive bytes.
`timescale 1ns/10ps
module testbench;
  localparam logic [31:0] BASE = 32'h100;
  localparam logic [31:0] ALT = 32'h240;
  localparam int ISW = 0, DMR = 1, S0R = 2, LRD = 3, FRD = 4, DFW = 5;
  localparam int ARX = 6, L2D = 7, S2D = 8, R2D = 9, MEM = 10, TOS = 11;
  localparam int OLL = 12, OLS = 13, HLL = 14, HLS = 15, DSW = 16;
  logic                i_clk = 1'b0;
  logic                i_rst_n = 1'b0;
  logic [16:0]         pl = '0;
  logic [7:0]          dat = 8'h00;
  logic                fv = 1'b0, dir = 1'b0, burst = 1'b0;
  abr_pkg::abr_instr_t ins = '0;
  abr_pkg::abr_evt_t   evt;
  logic                sv, req, irq;
  logic [7:0]          sd, ist, s0, s1, s2, dfc, ilat, fpd;
  logic [31:0]         dsp, exp;
  logic [23:0]         dbc;
  logic [5:0]          held;
  int                  err_total = 0, check_count = 0;
  abr_pkg::abr_op_t    t_op [7] = '{abr_pkg::OP_SELECT,
    abr_pkg::OP_RESELECT, abr_pkg::OP_WAIT_RESEL, abr_pkg::OP_WAIT_SEL,
    abr_pkg::OP_WAIT_SEL, abr_pkg::OP_WAIT_RESEL, abr_pkg::OP_SELECT};
  logic [3:0]          t_ev [7] = '{4'h4, 4'h8, 4'h8, 4'h4, 4'h8, 4'h4, 4'h2};
  always #5 i_clk = ~i_clk;
  abr_core dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_int_status_wr(pl[ISW]),
    .i_int_status_data(dat), .i_dsp_wr(pl[DSW]), .i_dsp_data(BASE),
    .i_dma_status_rd(pl[DMR]), .i_scsi_status_0_rd(pl[S0R]),
    .i_input_latch_rd(pl[LRD]), .i_fifo_port_rd(pl[FRD]),
    .i_dma_fifo_wr(pl[DFW]), .i_dma_fifo_data(dat), .i_fetch_valid(fv),
    .i_fetch(ins), .i_evt(evt), .i_dir_rx(dir), .i_burst_active(burst),
    .i_async_rx_valid(pl[ARX]), .i_async_rx_data(dat),
    .i_in_latch_to_dma(pl[L2D]), .i_sync_rx_valid(sv),
    .i_sync_rx_data(sd), .i_sfifo_to_dma(pl[S2D]), .i_rx_to_dma(pl[R2D]),
    .i_mem_byte(pl[MEM]), .i_dma_to_scsi(pl[TOS]),
    .i_out_latch_load(pl[OLL]), .i_out_latch_sent(pl[OLS]),
    .i_hold_load(pl[HLL]), .i_hold_sent(pl[HLS]), .o_fetch_req(req),
    .o_dsp(dsp), .o_int_status(ist), .o_scsi_status_0(s0),
    .o_scsi_status_1(s1), .o_scsi_status_2(s2), .o_byte_counter(dbc),
    .o_dma_fifo_count(dfc), .o_input_latch(ilat),
    .o_fifo_port_data(fpd), .o_abort_irq(irq)
  );
  abr_peer peer (.i_clk(i_clk), .o_evt(evt), .o_sv(sv), .o_sd(sd));
  task automatic tick;
    @(posedge i_clk);
    #1;
  endtask : tick
  // One-cycle strobe, then a gap
  task automatic pulse(input int k);
    pl[k] = 1'b1;
    tick;
    pl[k] = 1'b0;
    tick;
  endtask : pulse
  task automatic chk(input string n, input logic [47:0] s, e);
    check_count++;
    if (s !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic results;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results
  task automatic await(input logic w);
    int n;
    n = 0;
    while ((w ? irq : req) !== 1'b1 && n < 40) begin
      tick;
      n++;
    end
    if (n == 40) begin
      err_total++;
      results;
    end
  endtask : await
  // Start at BASE and hand over one instruction
  task automatic run(input abr_pkg::abr_op_t op, input logic [23:0] c);
    ins = '{op: op, alt: ALT, count: c};
    pulse(DSW);
    await(1'b0);
    fv = 1'b1;
    tick;
    fv = 1'b0;
    chk("fetch", dsp, BASE + abr_pkg::INST_BYTES);
  endtask : run
  task automatic abort_run;
    burst = 1'b1;
    dat = 8'h80;
    pulse(ISW);
    tick;
    chk("irq early", irq, 1'b0);
    chk("abort bit", ist[7], 1'b1);
    burst = 1'b0;
    await(1'b1);
    chk("halted", req, 1'b0);
    dat = 8'h00;
    pulse(ISW);
    pulse(DMR);
    chk("irq clr", irq, 1'b0);
  endtask : abort_run
  initial begin
    repeat (12) @(posedge i_clk);
    #1 i_rst_n = 1'b1;
    chk("reset", {req, ist}, 9'h000);
    for (int i = 0; i < 7; i++) begin
      peer.choose(4'h1);
      chk("unlinked", ist, 8'h00);
      run(t_op[i], 24'h4);
      peer.choose(t_ev[i]);
      exp = (i < 4) ? ALT : BASE + abr_pkg::INST_BYTES;
      chk("jump", dsp, exp);
      chk("conn", {s0, ist}, {(i < 6) ? 8'h10 : 8'h00, 8'h08});
      pulse(S0R);
      chk("chosen", s0, 8'h00);
      abort_run;
      chk("kept", {dsp, ist}, {exp, 8'h08});
    end
    // Stop op ends fetching
    run(abr_pkg::OP_STOP, 24'h0);
    tick;
    chk("stop", {req, dsp}, {1'b0, exp});
    // Send residue, then receive, then lose the peer
    run(abr_pkg::OP_MOVE, 24'h5);
    chk("residue", dbc, 24'h5);
    pulse(MEM);
    pulse(MEM);
    pulse(TOS);
    held = (dfc[5:0] - dbc[5:0]) & abr_pkg::DF_MASK;
    chk("dma held", {held, dbc}, {6'h1, 24'h3});
    dir = 1'b1;
    pulse(R2D);
    chk("no count", dbc, 24'h3);
    dat = 8'h80;
    pulse(ISW);
    chk("irq held", irq, 1'b0);
    pulse(MEM);
    chk("mem count", dbc, 24'h2);
    chk("irq drained", irq, 1'b1);
    dat = 8'h00;
    pulse(ISW);
    pulse(DMR);
    chk("irq clr", irq, 1'b0);
    peer.choose(4'h1);
    chk("disc", {req, dsp, ist}, {1'b0, exp, 8'h00});
    // Receive FIFO: overfill, pop, clear
    dat = 8'h40;
    pulse(DFW);
    for (int i = 0; i < 9; i++) begin
      peer.send(8'ha0 + 8'(i));
    end
    chk("rx count", s2, 8'h80);
    pulse(FRD);
    chk("pop", fpd, 8'ha0);
    pulse(FRD);
    pulse(S2D);
    chk("pop", {fpd, s2}, 16'ha150);
    pulse(DFW);
    chk("cleared", s2, 8'h00);
    // Latches and holding register
    dat = 8'h5a;
    pulse(ARX);
    chk("in latch", {s1, ilat}, 16'h805a);
    pulse(LRD);
    pulse(OLL);
    chk("out latch", s1, 8'h20);
    pulse(HLL);
    pulse(ARX);
    chk("hold", s1, 8'he0);
    pulse(L2D);
    pulse(OLS);
    pulse(HLS);
    chk("sent", s1, 8'h00);
    results;
  end
endmodule : testbench
